// File: src/bcvc_top.sv
// Purpose: capture, hold and report the boot configuration vector
// Assumes: straps synchronous to i_clk; apb slave with zero wait
// Notes:   i_rst_n is the fundamental reset input of the device
`timescale 1ns/1ps

module bcvc_top
  import bcvc_pkg::*;
(
  input  wire logic        i_clk,          // core clock
  input  wire logic        i_rst_n,        // fundamental reset, low
  input  wire logic        i_cclk_us,      // upstream common clock strap
  input  wire logic        i_cclk_ds,      // downstream common clock strap
  input  wire logic        i_slow,         // master bus slow strap
  input  wire logic        i_halt,         // reset halt strap
  input  wire logic [3:0]  i_mode,         // operating mode strap
  input  wire logic        i_ee_wr,        // eeprom override write strobe
  input  wire logic [31:0] i_ee_addr,      // eeprom write address
  input  wire logic [31:0] i_ee_data,      // eeprom write data
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [31:0] paddr,          // apb address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic [31:0]      prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  output logic             o_link_rst,     // link protocol reset
  output logic             o_core_rst,     // stacks held in reset
  output logic             o_us_common,    // upstream common clock
  output logic             o_ds_common,    // downstream common clock
  output logic             o_bus_slow,     // master bus at low rate
  output logic             o_eeprom_init,  // eeprom init mode
  output logic             o_failover,     // failover enabled
  output logic             o_upport2,      // port 2 is upstream
  output logic             o_mode_rsvd,    // reserved mode code
  output logic             o_pll_port0     // core clock from port 0 pll
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    BCVC_SEQ  = 2'b00,  // reset sequence running
    BCVC_HALT = 2'b01,  // halted, buses alive
    BCVC_RUN  = 2'b10   // normal operation
  } bcvc_phase_t;

  typedef struct packed {
    bcvc_phase_t phase;
    logic        first;     // first cycle after input reset release
    logic [7:0]  cnt;
    logic        us;
    logic        ds;
    logic        slow;
    logic        halt_cfg;  // captured or overridden halt
    logic [3:0]  mode;
    logic [3:0]  cold;      // straps as captured: us, ds, slow, halt
    logic        halt_sts;
    logic        halt_ctl;
    logic [31:0] rdata;
  } bcvc_state_t;

  bcvc_state_t st;
  bcvc_state_t next_st;

  logic dec_ee;
  logic dec_fo;
  logic dec_p2;
  logic dec_rs;

  // one decoder serves both the outputs and the readback
  bcvc_mode_dec u_dec (
    .i_mode     (st.mode),
    .o_eeprom   (dec_ee),
    .o_failover (dec_fo),
    .o_upport2  (dec_p2),
    .o_reserved (dec_rs)
  );

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [31:0] bcvc_bit(input int pos, input logic v);
    logic [31:0] r;
    r = BCVC_ZERO;
    r[pos] = v;
    return r;
  endfunction

  logic        wr_acc;
  logic        rd_acc;
  logic        in_rst;
  logic [11:0] a;

  assign a      = paddr[11:0];
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign in_rst = (st.phase == BCVC_SEQ);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // capture happens only on the first edge after release, never later
    if (st.first) begin
      next_st.first    = 1'b0;
      next_st.us       = i_cclk_us;
      next_st.ds       = i_cclk_ds;
      next_st.slow     = i_slow;
      next_st.halt_cfg = i_halt;
      next_st.mode     = i_mode;
      next_st.cold     = {i_halt, i_slow, i_cclk_ds, i_cclk_us};
      next_st.cnt      = 8'h00;
      next_st.phase    = BCVC_SEQ;
    end

    // overrides only during reset sequence; slow and mode stay fixed
    if (in_rst && !st.first) begin
      if (wr_acc && a == BCVC_ADDR_OVERRIDE) begin
        next_st.us       = pwdata[BCVC_OV_CCLK_US];
        next_st.ds       = pwdata[BCVC_OV_CCLK_DS];
        next_st.halt_cfg = pwdata[BCVC_OV_HALT];
      end
      if (i_ee_wr && i_ee_addr[11:0] == BCVC_ADDR_OVERRIDE) begin
        next_st.us       = i_ee_data[BCVC_OV_CCLK_US];
        next_st.ds       = i_ee_data[BCVC_OV_CCLK_DS];
        next_st.halt_cfg = i_ee_data[BCVC_OV_HALT];
      end
    end

    // reset sequence count up, then halt or run
    case (st.phase)
      BCVC_SEQ: begin
        if (!st.first) begin
          if (st.cnt == BCVC_SEQ_LAST) begin
            if (next_st.halt_cfg) begin
              next_st.phase    = BCVC_HALT;
              next_st.halt_sts = 1'b1;
              next_st.halt_ctl = 1'b1;
            end else begin
              next_st.phase = BCVC_RUN;
            end
          end else begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
      end
      BCVC_HALT: begin
        if (!st.halt_ctl)
          next_st.phase = BCVC_RUN;
      end
      BCVC_RUN: begin end
      default: next_st.phase = BCVC_SEQ;
    endcase

    // control writes: clearing halt releases, soft_fundamental_reset_bit restarts sequence
    if (wr_acc && a == BCVC_ADDR_CONTROL) begin
      // a clear landing on the halt-entry edge loses to the set
      if (!pwdata[BCVC_CT_HALT] &&
          !(in_rst && next_st.phase == BCVC_HALT))
        next_st.halt_ctl = 1'b0;
      if (pwdata[BCVC_CT_SOFT_FUNDAMENTAL_RESET_BIT]) begin
        next_st.phase    = BCVC_SEQ;
        next_st.cnt      = 8'h00;
        next_st.halt_sts = 1'b0;
        next_st.halt_ctl = 1'b0;
      end
    end
    if (i_ee_wr && i_ee_addr[11:0] == BCVC_ADDR_CONTROL &&
        !i_ee_data[BCVC_CT_HALT] &&
        !(in_rst && next_st.phase == BCVC_HALT))
      next_st.halt_ctl = 1'b0;

    // read data registered in the setup cycle
    next_st.rdata = BCVC_ZERO;
    if (rd_acc) begin
      case (a)
        BCVC_ADDR_STATUS:
          next_st.rdata = 32'(st.cold)
                        | (32'(st.mode) << BCVC_ST_MODE_LO)
                        | bcvc_bit(BCVC_ST_HALTED, st.halt_sts)
                        | bcvc_bit(BCVC_ST_INRST, in_rst);
        BCVC_ADDR_CONTROL:
          next_st.rdata = bcvc_bit(BCVC_CT_HALT, st.halt_ctl);
        BCVC_ADDR_OVERRIDE:
          next_st.rdata = bcvc_bit(BCVC_OV_CCLK_US, st.us)
                        | bcvc_bit(BCVC_OV_CCLK_DS, st.ds)
                        | bcvc_bit(BCVC_OV_HALT, st.halt_cfg);
        BCVC_ADDR_MODE:
          next_st.rdata = bcvc_bit(BCVC_MD_EEPROM, dec_ee)
                        | bcvc_bit(BCVC_MD_FAILOV, dec_fo)
                        | bcvc_bit(BCVC_MD_UPPORT2, dec_p2)
                        | bcvc_bit(BCVC_MD_RSVD, dec_rs)
                        | bcvc_bit(BCVC_MD_PLLSEL, 1'b1);
        default: next_st.rdata = BCVC_ZERO;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  // input reset clears everything but first, which it sets; capture waits for the release edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st          <= '0;
      st.first    <= 1'b1;
      st.phase    <= BCVC_SEQ;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  // zero-wait slave; unmapped addresses read zero with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (a != BCVC_ADDR_STATUS)
                 & (a != BCVC_ADDR_CONTROL) & (a != BCVC_ADDR_OVERRIDE)
                 & (a != BCVC_ADDR_MODE);
  assign prdata  = st.rdata;

  assign o_link_rst    = in_rst;
  assign o_core_rst    = (st.phase != BCVC_RUN);
  assign o_us_common   = st.us;
  assign o_ds_common   = st.ds;
  assign o_bus_slow    = st.slow;
  assign o_eeprom_init = dec_ee;
  assign o_failover    = dec_fo;
  assign o_upport2     = dec_p2;
  assign o_mode_rsvd   = dec_rs;
  assign o_pll_port0   = 1'b1;

endmodule // bcvc_top

// File: src/bcvc_pkg.sv
// Purpose: constants for the boot configuration vector capture block
// Assumes: 32-bit apb register bus, core clock 200 MHz
// Notes:   offsets and field positions are collected here
package bcvc_pkg;

  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [11:0] BCVC_ADDR_STATUS   = 12'h000;
  localparam logic [11:0] BCVC_ADDR_CONTROL  = 12'h004;
  localparam logic [11:0] BCVC_ADDR_OVERRIDE = 12'h008;
  localparam logic [11:0] BCVC_ADDR_MODE     = 12'h00C;

  // status fields
  localparam int BCVC_ST_CCLK_US = 0;
  localparam int BCVC_ST_CCLK_DS = 1;
  localparam int BCVC_ST_SLOW    = 2;
  localparam int BCVC_ST_HALT    = 3;
  localparam int BCVC_ST_MODE_LO = 4;
  localparam int BCVC_ST_HALTED  = 8;
  localparam int BCVC_ST_INRST   = 9;

  // control fields
  localparam int BCVC_CT_HALT    = 0;
  localparam int BCVC_CT_SOFT_FUNDAMENTAL_RESET_BIT    = 1;

  // override fields (writable only while in reset)
  localparam int BCVC_OV_CCLK_US = 0;
  localparam int BCVC_OV_CCLK_DS = 1;
  localparam int BCVC_OV_HALT    = 2;

  // mode decode fields
  localparam int BCVC_MD_EEPROM  = 0;
  localparam int BCVC_MD_FAILOV  = 1;
  localparam int BCVC_MD_UPPORT2 = 2;
  localparam int BCVC_MD_RSVD    = 3;
  localparam int BCVC_MD_PLLSEL  = 4;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int BCVC_CLK_MHZ     = 200;
  localparam int BCVC_RST_SEQ_NS  = 100;
  localparam int BCVC_RST_SEQ_CYC = (BCVC_RST_SEQ_NS * BCVC_CLK_MHZ
                                     + 999) / 1000;
  localparam logic [7:0] BCVC_SEQ_LAST = 8'(BCVC_RST_SEQ_CYC - 1);

  localparam logic [31:0] BCVC_ZERO = 32'h0000_0000;

endpackage

// File: src/bcvc_mode_dec.sv
// Purpose: decode the four-bit operating mode strap
// Assumes: code is already captured and stable
// Notes:   purely combinational
`timescale 1ns/1ps

module bcvc_mode_dec
  import bcvc_pkg::*;
(
  input  wire logic [3:0] i_mode,     // captured mode code
  output logic            o_eeprom,   // eeprom init requested
  output logic            o_failover, // upstream failover on
  output logic            o_upport2,  // port 2 upstream
  output logic            o_reserved  // reserved code
);

  // -------------------------------------------------------------------
  // decode table
  // -------------------------------------------------------------------
  // unlisted codes above b count as reserved too
  always_comb begin
    o_eeprom   = 1'b0;
    o_failover = 1'b0;
    o_upport2  = 1'b0;
    o_reserved = 1'b0;
    case (i_mode)
      4'h0: begin end
      4'h1: o_eeprom = 1'b1;
      4'h8: o_failover = 1'b1;
      4'h9: begin
        o_failover = 1'b1;
        o_eeprom   = 1'b1;
      end
      4'hA, 4'hB: begin
        o_failover = 1'b1;
        o_eeprom   = 1'b1;
        o_upport2  = 1'b1;
      end
      default: o_reserved = 1'b1;
    endcase
  end

endmodule // bcvc_mode_dec

// File: verif/bcvc_checker.sv
// Purpose: port assertions for bcvc_top
// Assumes: straps steady around the release edge
// Notes:   bound into every bcvc_top below
`timescale 1ns/1ps
module bcvc_checker
  import bcvc_pkg::*;
(
  input wire logic        i_clk,         // clock
  input wire logic        i_rst_n,       // reset
  input wire logic        i_cclk_us,     // strap
  input wire logic        i_cclk_ds,     // strap
  input wire logic        i_slow,        // strap
  input wire logic [3:0]  i_mode,        // strap
  input wire logic        i_ee_wr,       // eeprom
  input wire logic        psel,          // apb
  input wire logic        penable,       // apb
  input wire logic        pwrite,        // apb
  input wire logic [31:0] paddr,         // apb
  input wire logic [31:0] pwdata,        // apb
  input wire logic        o_link_rst,    // out
  input wire logic        o_core_rst,    // out
  input wire logic        o_us_common,   // out
  input wire logic        o_ds_common,   // out
  input wire logic        o_bus_slow,    // out
  input wire logic        o_eeprom_init, // out
  input wire logic        o_failover,    // out
  input wire logic        o_upport2,     // out
  input wire logic        o_mode_rsvd,   // out
  input wire logic        o_pll_port0    // out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // capture only at the first edge after release; later edges hold slow and mode
  a_strap_capture: assert property ($rose(i_rst_n) |=>
    {o_us_common, o_ds_common, o_bus_slow} ==
    $past({i_cclk_us, i_cclk_ds, i_slow})) else $error("strap capture");
  a_mode_reserved: assert property ($rose(i_rst_n) |=>
    o_mode_rsvd == ($past(i_mode) inside {[2:7], [12:15]}) &&
    o_eeprom_init == ($past(i_mode) inside {1, [9:11]}))
    else $error("mode decode");
  a_failover_decode: assert property ($rose(i_rst_n) |=>
    o_failover == ($past(i_mode) inside {[8:11]}) &&
    o_upport2 == ($past(i_mode) inside {10, 11})) else $error("failover");
  a_slow_held: assert property (!$rose(i_rst_n) |=>
    $stable(o_bus_slow)) else $error("slow mode moved");
  a_mode_held: assert property (!$rose(i_rst_n) |=>
    $stable({o_failover, o_upport2, o_mode_rsvd, o_eeprom_init}))
    else $error("mode moved");
  // sequence: high for 8 or more cycles, then low within 18 to 24
  a_seq_length: assert property ($rose(i_rst_n) |->
    o_link_rst [*8] ##[10:16] !o_link_rst) else $error("sequence length");
  // only a control write or eeprom write may end the halted state;
  // the release shows two edges after the clearing write
  a_halt_held: assert property (o_core_rst && !o_link_rst
    && !i_ee_wr && !$past(i_ee_wr)
    && !(psel && penable && pwrite && paddr[11:0] == BCVC_ADDR_CONTROL)
    && !$past(psel && penable && pwrite &&
              paddr[11:0] == BCVC_ADDR_CONTROL)
    |=> o_core_rst) else $error("halt left early");
  a_pll_source: assert property (o_pll_port0)
    else $error("core clock source");
  c_halted: cover property (o_core_rst && !o_link_rst);
  c_port2: cover property (o_failover && o_upport2);
  c_soft: cover property (psel && penable && pwrite && pwdata[1] &&
    paddr[11:0] == BCVC_ADDR_CONTROL);
endmodule // bcvc_checker

bind bcvc_top bcvc_checker u_chk (.*);

// File: verif/bcvc_strap_board.sv
// Purpose: board strap pins feeding bcvc_top
// Assumes: bench sets the vector while reset is low
// Notes:   no spread spectrum source is modelled
`timescale 1ns/1ps
module bcvc_strap_board (
  input  wire logic       i_clk,  // clock
  input  wire logic [7:0] i_vec,  // {mode,halt,slow,ds,us}
  output logic            o_us,   // strap
  output logic            o_ds,   // strap
  output logic            o_slow, // strap
  output logic            o_halt, // strap
  output logic [3:0]      o_mode  // strap
);
  // jumpers settle a cycle late; with no spread spectrum any mix of
  // common and separate clocks stays legal
  // mode pins move only when the bench asks, to probe misuse
  always_ff @(posedge i_clk) begin
    {o_mode, o_halt, o_slow, o_ds, o_us} <= i_vec;
  end
endmodule // bcvc_strap_board

// File: verif/bcvc_top_tb.sv
// Purpose: directed test of bcvc_top over apb
// Assumes: zero wait apb slave, 20 cycle reset sequence
// Notes:   straps come from bcvc_strap_board
`timescale 1ns/1ps
module bcvc_top_tb;
  import bcvc_pkg::*;
  logic        i_clk, i_rst_n, i_ee_wr, psel, penable, pwrite, err;
  logic        i_cclk_us, i_cclk_ds, i_slow, i_halt, pready, pslverr;
  logic        o_link_rst, o_core_rst, o_us_common, o_ds_common;
  logic        o_eeprom_init, o_failover, o_upport2, o_mode_rsvd;
  logic        o_bus_slow, o_pll_port0;
  logic [3:0]  i_mode;
  logic [7:0]  vec, v;
  logic [31:0] i_ee_addr, i_ee_data, paddr, pwdata, prdata, rd;
  int          errors, total_checks;
  localparam logic [31:0] ad_st = 32'(BCVC_ADDR_STATUS);
  localparam logic [31:0] ad_ct = 32'(BCVC_ADDR_CONTROL);
  localparam logic [31:0] ad_ov = 32'(BCVC_ADDR_OVERRIDE);
  localparam logic [31:0] ad_md = 32'(BCVC_ADDR_MODE);

  bcvc_strap_board u_board (.i_clk(i_clk), .i_vec(vec), .o_us(i_cclk_us),
    .o_ds(i_cclk_ds), .o_slow(i_slow), .o_halt(i_halt), .o_mode(i_mode));
  bcvc_top u_dut (.*);

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    do begin
      @(posedge i_clk);
      penable <= 1'b1;
      n++;
    end while (!(penable === 1'b1 && pready === 1'b1) && n < 50);
    if (n >= 50) begin
      errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst(input logic [7:0] x);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    vec <= x;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask

  // polls status until the reset sequence flag drops
  task automatic wait_seq;
    int n;
    n = 0;
    do begin
      apb(1'b0, ad_st, BCVC_ZERO);
      n++;
    end while (rd[BCVC_ST_INRST] !== 1'b0 && n < 60);
    if (n >= 60) begin
      errors++;
      results();
    end
  endtask

  function automatic logic [31:0] md(input int m);
    md = 32'h0000_0010;
    md[0] = m inside {1, [9:11]};
    md[1] = m inside {[8:11]};
    md[2] = m inside {10, 11};
    md[3] = m inside {[2:7], [12:15]};
  endfunction

  initial begin
    {errors, total_checks} = 0;
    {i_rst_n, i_ee_wr, psel, penable, pwrite} = 5'h00;
    {i_ee_addr, i_ee_data, paddr, pwdata} = {4{BCVC_ZERO}};
    vec = 8'h00;
    v = 8'h00;
    repeat (20) @(posedge i_clk);
    // every mode code, then straps flipped behind the device's back
    for (int m = 0; m < 16; m++) begin
      v = {4'(m), 1'b0, 3'(m)};
      rst(v);
      wait_seq();
      chk(rd & 32'h0000_00FF, 32'(v));
      chk(32'({o_bus_slow, o_ds_common, o_us_common}), 32'(v[2:0]));
      chk(32'(o_core_rst), BCVC_ZERO);
      vec <= ~v;
      apb(1'b0, ad_md, BCVC_ZERO);
      chk(rd, md(m));
      apb(1'b0, ad_st, BCVC_ZERO);
      chk(rd & 32'h0000_00FF, 32'(v));
    end
    // halt strap with overrides from eeprom then apb
    rst(8'h08);
    @(posedge i_clk);
    i_ee_wr <= 1'b1;
    i_ee_addr <= ad_ov;
    i_ee_data <= 32'h0000_0005;
    @(posedge i_clk);
    i_ee_wr <= 1'b0;
    apb(1'b0, ad_ov, BCVC_ZERO);
    chk(rd & 32'h0000_0007, 32'h0000_0005);
    apb(1'b1, ad_ov, 32'h0000_0007);
    wait_seq();
    chk(rd & 32'h0000_03FF, 32'h0000_0108);
    chk(32'({o_core_rst, o_ds_common, o_us_common}), 32'h0000_0007);
    apb(1'b1, ad_ov, BCVC_ZERO);
    apb(1'b0, ad_ov, BCVC_ZERO);
    chk(rd & 32'h0000_0007, 32'h0000_0007);
    apb(1'b1, ad_ct, BCVC_ZERO);
    // halt leaves two edges after the clear; look once it has settled
    repeat (2) @(posedge i_clk);
    chk(32'(o_core_rst), BCVC_ZERO);
    // soft reset reuses held values although the pins moved
    vec <= 8'h00;
    apb(1'b1, ad_ct, 32'h0000_0002);
    wait_seq();
    chk(rd & 32'h0000_03FF, 32'h0000_0108);
    chk(32'({o_ds_common, o_us_common}), 32'h0000_0003);
    apb(1'b0, 32'h0000_0010, BCVC_ZERO);
    chk({rd[30:0], err}, 32'h0000_0001);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    chk(32'({o_link_rst, o_core_rst, o_us_common}), 32'h0000_0006);
    results();
  end
endmodule // bcvc_top_tb
